// ==== inc/acp_defines.svh ====
// constants of the serial calibration command port
`ifndef ACP_DEFINES_SVH
`define ACP_DEFINES_SVH

// command byte layout
`define ACP_CMD_BITS        5'd8
`define ACP_CMD_CAL_BIT     7
`define ACP_CMD_RW_BIT      3
`define ACP_DATA_BITS       5'd24

// calibration types
`define ACP_CAL_SELF_OFS    3'h1
`define ACP_CAL_SELF_GAIN   3'h2
`define ACP_CAL_SYS_OFS     3'h5
`define ACP_CAL_SYS_GAIN    3'h6

// register access command codes, low three bits
`define ACP_REG_OFS_CODE    3'h1
`define ACP_REG_GAIN_CODE   3'h2
`define ACP_REG_CFG_CODE    3'h3

// resync bytes and the run of ones that must precede the final zero
`define ACP_RESYNC_LEAD     8'hff
`define ACP_RESYNC_FINAL    8'hfe
`define ACP_RESYNC_ONES     4'hf

// implemented setups and channels
`define ACP_NUM_SETUPS      5'h10
`define ACP_NUM_CHANNELS    4'h8

// shadow register file: 8 offset, 8 gain, 1 configuration
`define ACP_GAIN_BASE       2'h1
`define ACP_CFG_ADDR        5'h10
`define ACP_NUM_REGS        17
`define ACP_REG_RESET       24'h000000

`endif

// ==== inc/acp_pkg.sv ====
// types of the serial calibration command port
package acp_pkg;

  typedef enum logic [1:0] {
    ACP_ST_CMD,
    ACP_ST_WDATA,
    ACP_ST_RDATA
  } acp_state_t;

  typedef struct packed {
    logic [3:0] setup_pointer;
    logic [2:0] calibration_type;
  } acp_cal_t;

  typedef struct packed {
    logic [4:0]  addr;
    logic [23:0] data;
  } acp_wr_t;

endpackage

// ==== verilog/acp_port.sv ====
// serial command port: calibration commands, register transfers, resync
`timescale 1ns/100ps
`include "acp_defines.svh"
module acp_port (
  // system side
  input  wire logic          i_clock,
  input  wire logic          i_rst,
  // serial link
  input  wire logic          i_sclk,
  input  wire logic          i_cs_n,
  input  wire logic          i_sdi,
  output logic               o_sdo,
  output logic               o_sdo_oe_n,
  // decoded events, system clock
  output logic               o_cal_valid,
  output acp_pkg::acp_cal_t  o_cal,
  output logic               o_wr_valid,
  output acp_pkg::acp_wr_t   o_wr
);

  // link domain
  logic                 link_rst;
  acp_pkg::acp_state_t  state_q;
  logic [4:0]           bit_cnt_q;
  logic [4:0]           bit_cnt_d;
  logic [23:0]          in_sh_q;
  logic [3:0]           ones_q;
  logic [4:0]           addr_q;
  logic                 sdo_q;
  logic [23:0]          regs_q [`ACP_NUM_REGS];
  logic [7:0]           cmd_byte;
  logic [23:0]          data_word;
  logic [23:0]          rd_word;
  logic                 byte_done;
  logic                 word_done;
  logic                 realign;
  logic                 is_resync;
  logic                 cal_ok;
  logic                 reg_ok;
  logic                 is_read;
  logic [4:0]           reg_addr;
  logic                 cal_tgl_q;
  acp_pkg::acp_cal_t    cal_word_q;
  logic                 wr_tgl_q;
  acp_pkg::acp_wr_t     wr_word_q;

  // system domain
  logic [2:0]           cal_sync_q;
  logic [2:0]           wr_sync_q;
  logic                 cal_seen;
  logic                 wr_seen;

  // a deselect clears the framing, so a half-sent byte cannot linger
  assign link_rst = i_rst | i_cs_n;

  assign o_sdo_oe_n = i_cs_n;
  assign o_sdo = sdo_q;

  assign cmd_byte = {in_sh_q[6:0], i_sdi};
  assign data_word = {in_sh_q[22:0], i_sdi};
  assign rd_word = regs_q[addr_q];

  always_comb begin
    byte_done = (state_q == acp_pkg::ACP_ST_CMD) && (bit_cnt_q == `ACP_CMD_BITS - 5'd1);
    word_done = (state_q != acp_pkg::ACP_ST_CMD) && (bit_cnt_q == `ACP_DATA_BITS - 5'd1);
    realign = (state_q == acp_pkg::ACP_ST_CMD) && !i_sdi && (ones_q == `ACP_RESYNC_ONES);
    is_resync = (cmd_byte == `ACP_RESYNC_LEAD) || (cmd_byte == `ACP_RESYNC_FINAL);
    is_read = cmd_byte[`ACP_CMD_RW_BIT];
    cal_ok = 1'b0;
    reg_ok = 1'b0;
    reg_addr = 5'h00;
    if (cmd_byte[`ACP_CMD_CAL_BIT]) begin
      case (cmd_byte[2:0])
        `ACP_CAL_SELF_OFS,
        `ACP_CAL_SELF_GAIN,
        `ACP_CAL_SYS_OFS,
        `ACP_CAL_SYS_GAIN: cal_ok = !is_resync && ({1'b0, cmd_byte[6:3]} < `ACP_NUM_SETUPS);
        default: cal_ok = 1'b0;
      endcase
    end else begin
      case (cmd_byte[2:0])
        `ACP_REG_OFS_CODE: begin
          reg_ok = {1'b0, cmd_byte[6:4]} < `ACP_NUM_CHANNELS;
          reg_addr = {2'h0, cmd_byte[6:4]};
        end
        `ACP_REG_GAIN_CODE: begin
          reg_ok = {1'b0, cmd_byte[6:4]} < `ACP_NUM_CHANNELS;
          reg_addr = {`ACP_GAIN_BASE, cmd_byte[6:4]};
        end
        `ACP_REG_CFG_CODE: begin
          reg_ok = cmd_byte[6:4] == 3'h0;
          reg_addr = `ACP_CFG_ADDR;
        end
        default: reg_ok = 1'b0;
      endcase
    end
  end

  // input shifter; only the low 23 bits are ever read
  always_ff @(posedge i_sclk or posedge link_rst) begin
    if (link_rst) begin
      in_sh_q <= 24'h000000;
    end else begin
      in_sh_q <= data_word;
    end
  end

  // saturating run of ones, counted only while waiting for a command
  always_ff @(posedge i_sclk or posedge link_rst) begin
    if (link_rst) begin
      ones_q <= 4'h0;
    end else if (state_q != acp_pkg::ACP_ST_CMD) begin
      ones_q <= 4'h0;
    end else if (!i_sdi) begin
      ones_q <= 4'h0;
    end else if (ones_q != `ACP_RESYNC_ONES) begin
      ones_q <= ones_q + 4'h1;
    end
  end

  // without chip select the ones-run resync is the only way back to bit 0
  always_comb begin
    bit_cnt_d = bit_cnt_q + 5'h01;
    case (state_q)
      acp_pkg::ACP_ST_CMD: begin
        if (realign || byte_done) begin
          bit_cnt_d = 5'h00;
        end
      end
      acp_pkg::ACP_ST_WDATA,
      acp_pkg::ACP_ST_RDATA: begin
        if (word_done) begin
          bit_cnt_d = 5'h00;
        end
      end
      default: bit_cnt_d = 5'h00;
    endcase
  end

  always_ff @(posedge i_sclk or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_q <= 5'h00;
    end else begin
      bit_cnt_q <= bit_cnt_d;
    end
  end

  // transfer phase; a realigning zero never starts a transfer
  always_ff @(posedge i_sclk or posedge link_rst) begin
    if (link_rst) begin
      state_q <= acp_pkg::ACP_ST_CMD;
    end else begin
      case (state_q)
        acp_pkg::ACP_ST_CMD: begin
          if (byte_done && !realign && reg_ok) begin
            state_q <= is_read ? acp_pkg::ACP_ST_RDATA : acp_pkg::ACP_ST_WDATA;
          end
        end
        acp_pkg::ACP_ST_WDATA,
        acp_pkg::ACP_ST_RDATA: begin
          if (word_done) begin
            state_q <= acp_pkg::ACP_ST_CMD;
          end
        end
        default: state_q <= acp_pkg::ACP_ST_CMD;
      endcase
    end
  end

  // register address latched with the command byte
  always_ff @(posedge i_sclk or posedge link_rst) begin
    if (link_rst) begin
      addr_q <= 5'h00;
    end else if (byte_done && !realign && reg_ok) begin
      addr_q <= reg_addr;
    end
  end

  // shadow registers survive deselect; only the system reset clears them
  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < `ACP_NUM_REGS; i++) begin
        regs_q[i] <= `ACP_REG_RESET;
      end
    end else if (word_done && state_q == acp_pkg::ACP_ST_WDATA) begin
      regs_q[addr_q] <= data_word;
    end
  end

  // read data changes on the falling edge so the host samples it on rising
  always_ff @(negedge i_sclk or posedge link_rst) begin
    if (link_rst) begin
      sdo_q <= 1'b0;
    end else if (state_q == acp_pkg::ACP_ST_RDATA) begin
      sdo_q <= rd_word[5'd23 - bit_cnt_q];
    end else begin
      sdo_q <= 1'b0;
    end
  end

  // event words hold until the next event; a deselect must not toggle them
  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      cal_tgl_q <= 1'b0;
      cal_word_q <= '0;
    end else if (byte_done && !realign && cal_ok) begin
      cal_tgl_q <= ~cal_tgl_q;
      cal_word_q <= '{setup_pointer: cmd_byte[6:3], calibration_type: cmd_byte[2:0]};
    end
  end

  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      wr_tgl_q <= 1'b0;
      wr_word_q <= '0;
    end else if (word_done && state_q == acp_pkg::ACP_ST_WDATA) begin
      wr_tgl_q <= ~wr_tgl_q;
      wr_word_q <= '{addr: addr_q, data: data_word};
    end
  end

  // toggle crossing; words are stable long before the toggle is seen
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cal_sync_q <= 3'h0;
    end else begin
      cal_sync_q <= {cal_sync_q[1:0], cal_tgl_q};
    end
  end

  // only the second flop reads the first, which may be metastable
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wr_sync_q <= 3'h0;
    end else begin
      wr_sync_q <= {wr_sync_q[1:0], wr_tgl_q};
    end
  end

  assign cal_seen = cal_sync_q[1] ^ cal_sync_q[2];
  assign wr_seen = wr_sync_q[1] ^ wr_sync_q[2];

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_cal_valid <= 1'b0;
      o_cal <= '0;
    end else begin
      o_cal_valid <= cal_seen;
      if (cal_seen) begin
        o_cal <= cal_word_q;
      end
    end
  end

  // events closer than three system clocks apart would be lost
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_wr_valid <= 1'b0;
      o_wr <= '0;
    end else begin
      o_wr_valid <= wr_seen;
      if (wr_seen) begin
        o_wr <= wr_word_q;
      end
    end
  end

endmodule

// ==== testbench/acp_port_assertions.sv ====
// checker of the serial calibration command port
`timescale 1ns/100ps
module acp_port_checker (
  input wire logic              i_clock,
  input wire logic              i_rst,
  input wire logic              i_cs_n,
  input wire logic              o_sdo,
  input wire logic              o_sdo_oe_n,
  input wire logic              o_cal_valid,
  input wire acp_pkg::acp_cal_t o_cal,
  input wire logic              o_wr_valid,
  input wire acp_pkg::acp_wr_t  o_wr
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence s_cal_pulse; o_cal_valid ##1 !o_cal_valid; endsequence
  sequence s_wr_pulse; o_wr_valid ##1 !o_wr_valid; endsequence
  a_oe_follows_cs: assert property (o_sdo_oe_n == i_cs_n)
    else $error("sdo enable differs from chip select");
  a_sdo_idle_low: assert property (i_cs_n [*2] |-> o_sdo == 1'b0)
    else $error("sdo active while deselected");
  a_cal_one_pulse: assert property (o_cal_valid |-> s_cal_pulse)
    else $error("calibration pulse too long");
  a_wr_one_pulse: assert property (o_wr_valid |-> s_wr_pulse)
    else $error("write pulse too long");
  a_cal_type_legal: assert property (o_cal_valid |-> o_cal[2:0] inside {1, 2, 5, 6})
    else $error("reserved calibration type issued");
  a_cal_holds: assert property (!o_cal_valid |-> $stable(o_cal))
    else $error("calibration fields moved");
  a_wr_addr_range: assert property (o_wr_valid |-> o_wr.addr <= 5'h10)
    else $error("write address out of range");
  a_cs_blocks_events: assert property (i_cs_n [*6] |-> !o_cal_valid && !o_wr_valid)
    else $error("event while deselected");
endmodule
bind acp_port acp_port_checker chk_u (.i_clock(i_clock), .i_rst(i_rst), .i_cs_n(i_cs_n),
  .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n), .o_cal_valid(o_cal_valid), .o_cal(o_cal),
  .o_wr_valid(o_wr_valid), .o_wr(o_wr));

// ==== testbench/acp_host.sv ====
// host model: drives chip select, serial clock and data, samples sdo
`timescale 1ns/100ps
module acp_host (
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdi,
  input  wire logic i_sdo
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b1;
  end
  // n bits msb first; sclk stands still outside frames
  task automatic frame(input int n, input logic [31:0] v, input bit sel, input bit keep,
                       output logic [31:0] r);
    r = 32'h0;
    o_cs_n = !sel;
    #23;
    for (int k = n - 1; k >= 0; k--) begin
      o_sdi = v[k];
      #40 o_sclk = 1'b1;
      r = {r[30:0], i_sdo};
      #40 o_sclk = 1'b0;
    end
    #20 o_cs_n = !keep;
    o_sdi = !o_sdi;
    #1000;
  endtask
endmodule

// ==== testbench/tb_acp_port.sv ====
// testbench of the serial calibration command port
`timescale 1ns/100ps
module tb_acp_port;
  logic               i_clock = 1'b0;
  logic               i_rst = 1'b1;
  logic               sclk, cs_n, sdi, o_sdo, o_sdo_oe_n, o_cal_valid, o_wr_valid;
  acp_pkg::acp_cal_t  o_cal;
  acp_pkg::acp_wr_t   o_wr;
  wire                sdo_w = o_sdo_oe_n ? 1'bz : o_sdo;
  logic [31:0]        exp_q[$];
  logic [31:0]        r, d, seen_v;
  logic [7:0]         c;
  logic [4:0]         a;
  logic [3:0]         p;
  int                 miscompares = 0;
  int                 tests_run = 0;
  int                 seed = 32'h5e635bc3;
  always #50 i_clock = ~i_clock;
  acp_port dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_sdi(sdi), .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n), .o_cal_valid(o_cal_valid),
    .o_cal(o_cal), .o_wr_valid(o_wr_valid), .o_wr(o_wr));
  acp_host host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo_w));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // every event takes the oldest note; an unexpected one compares against its inverse
  always @(posedge i_clock) begin
    if (o_cal_valid === 1'b1 || o_wr_valid === 1'b1) begin
      seen_v = o_cal_valid ? {1'b1, 24'h0, o_cal} : {3'h0, o_wr};
      check("event", seen_v, exp_q.size() > 0 ? exp_q.pop_front() : ~seen_v);
    end
  end
  initial begin
    #500000;
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge i_clock);
    i_rst <= 1'b0;
    #17;
    for (int t = 0; t < 8; t++) begin
      p = (t == 5) ? 4'hf : 4'({$random(seed)} % 15);
      if (t inside {1, 2, 5, 6}) exp_q.push_back({1'b1, 24'h0, p, 3'(t)});
      host_u.frame(8, {24'h0, 1'b1, p, 3'(t)}, 1'b1, 1'b0, r);
    end
    for (int k = 0; k < 3; k++) begin
      p = 4'({$random(seed)} % 8);
      d = $random(seed);
      a = (k == 2) ? 5'h10 : {1'b0, k[0], p[2:0]};
      c = (k == 2) ? 8'h03 : {1'b0, p[2:0], 1'b0, 3'(k + 1)};
      exp_q.push_back({3'h0, a, d[23:0]});
      host_u.frame(32, {c, d[23:0]}, 1'b1, 1'b0, r);
      host_u.frame(32, {c | 8'h08, ~d[23:0]}, 1'b1, 1'b0, r);
      check("read", {8'h0, r[23:0]}, {8'h0, d[23:0]});
    end
    // deselected clocks must leave no trace
    host_u.frame(8, 32'h89, 1'b0, 1'b0, r);
    // tied-low select: misaligned ones, resync, then a command
    host_u.frame(3, 32'h4, 1'b1, 1'b1, r);
    host_u.frame(24, 32'hfffffe, 1'b1, 1'b1, r);
    exp_q.push_back({1'b1, 24'h0, 7'h35});
    host_u.frame(8, 32'hb5, 1'b1, 1'b1, r);
    // a write aborted by deselect, then a fresh command
    host_u.frame(12, 32'h020, 1'b1, 1'b0, r);
    exp_q.push_back({1'b1, 24'h0, 7'h42});
    host_u.frame(8, 32'hc2, 1'b1, 1'b0, r);
    repeat (20) @(posedge i_clock);
    check("pending", exp_q.size(), 32'h0);
    print_verdict();
  end
endmodule
